// ### call_stack_and_table_read.sv
// program control: return stack, program counter and table reads
// assumes a decoder issuing one op per accepted cycle on core_req
//
// Summary of operation
// - calls advance index, seventh call sets overflow
// - overflow flag survives any number of returns
// - empty-stack return sets overflow, index to five
// - program memory is 4K words of 16 bits
// - reset loads program counter with vector zero
// - table address is pointer high and low
// - low byte to register, high to table high
// - normal table reads stay in sector zero, last-page ones read page 0xF
// - table high byte readable and writable
// - every table op takes two cycles
// - alu result and flags updated together
// - programming pins belong only to programmer
// - debug variant: shared pin functions disabled
// - six levels, calls push, returns restore
// - only software clears the overflow flag
// - stack full withholds interrupt acknowledge
// - reset leaves stack empty, index zero
`timescale 1ns/1ps
`include "pcstk_consts.svh"
module call_stack_and_table_read (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   output logic irq, // level interrupt
   input wire pcstk_pkg::core_req_t core_req, // op from decoder
   output logic core_ready, // op accepted this cycle
   output pcstk_pkg::table_wr_t table_wr, // table low byte write
   output logic [`PC_W-1:0] pc, // program counter
   output logic [15:0] fetch_word, // fetched instruction
   output logic fetch_valid, // fetch_word is an instruction
   input wire logic int_request, // enabled interrupt pending
   output logic int_ack, // interrupt acknowledged, pulse
   input wire logic [7:0] alu_result, // alu result
   input wire logic [7:0] alu_dest, // alu destination
   input wire logic alu_valid, // alu op completes
   input wire logic [3:0] alu_flags, // carry, borrow and others
   output logic [7:0] alu_wr_data, // registered result
   output logic [7:0] alu_wr_dest, // registered destination
   output logic alu_wr_valid, // result write strobe
   output logic [3:0] status_flags, // status register flags
   input wire logic debug_variant, // emulation variant strap
   input wire logic prog_mode, // in-circuit programming active
   input wire logic prog_serial_data_pin_in, // programming data in
   input wire logic debug_serial_data_pin_in, // debug data in
   input wire logic shared_data_out, // user function on data pin
   input wire logic shared_data_oe, // user drive enable
   output logic shared_data_in, // pin level seen by user
   output logic pin_data_out, // data pin drive value
   output logic pin_data_oe // data pin enable
);
   // ====================================================
   // stack
   logic [`PC_W-1:0] stack_mem [0:`STK_LEVELS-1];
   logic [2:0] stack_level_index;
   logic stack_overflow_flag;
   logic stack_full;
   pcstk_pkg::tstate_t tstate;
   logic [15:0] pm_rdata;

   wire is_call = core_req.op == pcstk_pkg::op_call;
   wire is_ret = core_req.op == pcstk_pkg::op_return
      || core_req.op == pcstk_pkg::op_return_int;
   wire is_tbl = core_req.op[2];
   wire in_fetch = tstate == pcstk_pkg::st_fetch;
   // full means six pushes outstanding without a return
   wire do_ack = in_fetch && int_request && !stack_full
      && core_req.op == pcstk_pkg::op_none;
   wire do_push = in_fetch && (is_call || do_ack);
   wire do_pop = in_fetch && is_ret;
   wire [2:0] idx_inc = (stack_level_index == `STK_LAST) ?
      `STK_ZERO : stack_level_index + 3'h1;
   wire [2:0] idx_dec = (stack_level_index == `STK_ZERO) ?
      `STK_LAST : stack_level_index - 3'h1;
   // overflow when a push lands on a full stack, or pop from empty
   wire ovf_event = (do_push && stack_full)
      || (do_pop && stack_level_index == `STK_ZERO && !stack_full);
   wire [2:0] pop_slot = idx_dec;

   // ====================================================
   // apb decode
   wire apb_wr = psel && penable && pwrite;
   wire [7:0] table_pointer_low;
   wire [7:0] table_pointer_high;
   logic [15:0] table_ptr;
   logic [7:0] table_high_byte;
   logic [`INT_W-1:0] int_status;
   logic [`INT_W-1:0] int_mask;
   logic [`PC_W-1:0] pm_addr;
   logic [`PC_W-1:0] pc_next_fetch;
   assign table_pointer_low = table_ptr[7:0];
   assign table_pointer_high = table_ptr[15:8];
   wire sel_stack = paddr == `A_STACK;
   wire sel_tptr = paddr == `A_TABLE_PTR;
   wire sel_thigh = paddr == `A_TABLE_HIGH;
   wire sel_pc = paddr == `A_PC;
   wire sel_ist = paddr == `A_INT_STATUS;
   wire sel_imask = paddr == `A_INT_MASK;
   wire sel_ctl = paddr == `A_CONTROL;
   wire sel_paddr = paddr == `A_PM_ADDR;
   wire sel_pdata = paddr == `A_PM_DATA;
   wire mapped = sel_stack || sel_tptr || sel_thigh || sel_pc
      || sel_ist || sel_imask || sel_ctl || sel_paddr || sel_pdata;
   wire osf_clear = apb_wr && sel_stack && !pwdata[`OSF_BIT];
   wire pm_we = apb_wr && sel_pdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ====================================================
   // table read
   // normal ops force sector zero high bits; extended ops use full pointer
   wire [`PC_W-1:0] tbl_addr_full =
      {table_pointer_high[3:0], table_pointer_low};
   wire [`PC_W-1:0] tbl_addr_s0 =
      {`SECTOR0_HIGH, table_pointer_low};
   wire tbl_ext = core_req.op == pcstk_pkg::op_extended_table_read
      || core_req.op == pcstk_pkg::op_extended_table_read_last_page;
   wire tbl_last = core_req.op == pcstk_pkg::op_table_read_last_page
      || core_req.op == pcstk_pkg::op_extended_table_read_last_page;
   // last page reads ignore the high pointer byte and use page 0xF
   wire [`PC_W-1:0] tbl_addr = tbl_last ?
      {`LAST_PG, table_pointer_low} : (tbl_ext ? tbl_addr_full : tbl_addr_s0);
   logic [7:0] tbl_dest;
   logic tbl_pending;
   // a new table op takes the read port in its first cycle, then stalls one cycle
   assign core_ready = in_fetch;
   wire [`PC_W-1:0] rd_addr = (in_fetch && is_tbl) ? tbl_addr : pc;
   assign pc_next_fetch = pc + 12'h001;

   prog_mem u_mem (
      .pclk(pclk),
      .we(pm_we),
      .waddr(pm_addr),
      .wdata(pwdata[15:0]),
      .raddr(rd_addr),
      .rdata(pm_rdata)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tstate <= pcstk_pkg::st_fetch;
         tbl_dest <= 8'h00;
         tbl_pending <= 1'b0;
      end else begin
         tbl_pending <= in_fetch && is_tbl;
         if (in_fetch && is_tbl) begin
            tstate <= pcstk_pkg::st_table;
            tbl_dest <= core_req.dest;
         end else begin
            tstate <= pcstk_pkg::st_fetch;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         table_wr <= '0;
         table_high_byte <= 8'h00;
      end else begin
         table_wr.valid <= tbl_pending;
         table_wr.dest <= tbl_dest;
         table_wr.data <= pm_rdata[7:0];
         if (tbl_pending) begin
            table_high_byte <= pm_rdata[15:8];
         end else if (apb_wr && sel_thigh) begin
            table_high_byte <= pwdata[7:0];
         end
      end
   end

   // ====================================================
   // program counter and stack
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc <= `RESET_VECTOR;
         stack_level_index <= `STK_ZERO;
         stack_full <= 1'b0;
         stack_overflow_flag <= 1'b0;
         int_ack <= 1'b0;
      end else begin
         int_ack <= do_ack;
         if (do_push) begin
            stack_mem[stack_level_index] <= pc;
            stack_level_index <= idx_inc;
            stack_full <= idx_inc == `STK_ZERO || stack_full;
            pc <= is_call ? core_req.target : `INT_VECTOR;
         end else if (do_pop) begin
            pc <= stack_mem[pop_slot];
            stack_level_index <= idx_dec;
            stack_full <= 1'b0;
         end else if (in_fetch && !is_tbl) begin
            pc <= pc_next_fetch;
         end
         // set wins over clear; hardware never clears it
         if (ovf_event) begin
            stack_overflow_flag <= 1'b1;
         end else if (osf_clear) begin
            stack_overflow_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_word <= 16'h0000;
         fetch_valid <= 1'b0;
      end else begin
         fetch_valid <= !tbl_pending && presetn;
         fetch_word <= pm_rdata;
      end
   end

   // ====================================================
   // alu writeback
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alu_wr_data <= 8'h00;
         alu_wr_dest <= 8'h00;
         alu_wr_valid <= 1'b0;
         status_flags <= 4'h0;
      end else begin
         alu_wr_valid <= alu_valid;
         if (alu_valid) begin
            alu_wr_data <= alu_result;
            alu_wr_dest <= alu_dest;
            status_flags <= alu_flags;
         end
      end
   end

   // ====================================================
   // registers, interrupts
   wire [`INT_W-1:0] int_events;
   assign int_events[`INT_OVF] = ovf_event;
   assign int_events[`INT_TBL] = tbl_pending;
   genvar gi;
   generate
      for (gi = 0; gi < `INT_W; gi++) begin : g_int
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               int_status[gi] <= 1'b0;
            end else if (int_events[gi]) begin
               int_status[gi] <= 1'b1;
            end else if (apb_wr && sel_ist && pwdata[gi]) begin
               int_status[gi] <= 1'b0;
            end
         end
      end
   endgenerate
   assign irq = |(int_status & int_mask);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         table_ptr <= 16'h0000;
         int_mask <= '0;
         pm_addr <= 12'h000;
      end else if (apb_wr) begin
         if (sel_tptr) begin
            table_ptr <= pwdata[15:0];
         end
         if (sel_imask) begin
            int_mask <= pwdata[`INT_W-1:0];
         end
         if (sel_paddr) begin
            pm_addr <= pwdata[`PC_W-1:0];
         end
      end
   end

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (sel_stack) begin
         rd_mux = {24'h0, stack_overflow_flag, 4'h0, stack_level_index};
      end else if (sel_tptr) begin
         rd_mux = {16'h0, table_ptr};
      end else if (sel_thigh) begin
         rd_mux = {24'h0, table_high_byte};
      end else if (sel_pc) begin
         rd_mux = {20'h0, pc};
      end else if (sel_ist) begin
         rd_mux = {30'h0, int_status};
      end else if (sel_imask) begin
         rd_mux = {30'h0, int_mask};
      end else if (sel_ctl) begin
         rd_mux = {29'h0, debug_variant, prog_mode, stack_full};
      end else if (sel_paddr) begin
         rd_mux = {20'h0, pm_addr};
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= rd_mux;
      end
   end

   // ====================================================
   // shared data pin: programmer or debug link own it exclusively
   wire pin_owned = prog_mode || debug_variant;
   assign pin_data_out = pin_owned ? 1'b0 : shared_data_out;
   assign pin_data_oe = pin_owned ? 1'b0 : shared_data_oe;
   assign shared_data_in = pin_owned ? 1'b0 :
      prog_serial_data_pin_in;
   wire unused_dbg = debug_serial_data_pin_in;
endmodule

// ### pcstk_consts.svh
// constants for the call stack and table read block
// assumes inclusion by the package and the design modules
`ifndef PCSTK_CONSTS_SVH
`define PCSTK_CONSTS_SVH
`define PC_W 12
`define PM_DEPTH 4096
`define STK_LEVELS 6
`define STK_LAST 3'h5
`define STK_ZERO 3'h0
`define RESET_VECTOR 12'h000
`define SECTOR0_HIGH 4'h0
`define LAST_PG 4'hF
`define INT_VECTOR 12'h004
`define A_STACK 12'h000
`define A_TABLE_PTR 12'h004
`define A_TABLE_HIGH 12'h008
`define A_PC 12'h00C
`define A_INT_STATUS 12'h010
`define A_INT_MASK 12'h014
`define A_CONTROL 12'h018
`define A_PM_ADDR 12'h01C
`define A_PM_DATA 12'h020
`define OSF_BIT 7
`define INT_OVF 0
`define INT_TBL 1
`define INT_W 2
`endif

// ### pcstk_pkg.sv
// types shared by the call stack and table read block
// assumes pcstk_consts.svh in the include path
`include "pcstk_consts.svh"
package pcstk_pkg;
   typedef enum logic [2:0] {
      op_none = 3'b000,
      op_call = 3'b001,
      op_return = 3'b010,
      op_return_int = 3'b011,
      op_table_read = 3'b100,
      op_table_read_last_page = 3'b101,
      op_extended_table_read = 3'b110,
      op_extended_table_read_last_page = 3'b111
   } op_t;
   typedef struct packed {
      op_t op;
      logic [`PC_W-1:0] target;
      logic [7:0] dest;
   } core_req_t;
   typedef struct packed {
      logic valid;
      logic [7:0] dest;
      logic [7:0] data;
   } table_wr_t;
   typedef enum logic [0:0] {
      st_fetch = 1'b0,
      st_table = 1'b1
   } tstate_t;
endpackage

// ### prog_mem.sv
// program memory, one synchronous read port, one write port
// assumes a single clock; contents come from software writes
`timescale 1ns/1ps
`include "pcstk_consts.svh"
module prog_mem (
   input wire logic pclk, // clock
   input wire logic we, // write strobe
   input wire logic [`PC_W-1:0] waddr, // write address
   input wire logic [15:0] wdata, // write word
   input wire logic [`PC_W-1:0] raddr, // read address
   output logic [15:0] rdata // read word, one cycle later
);
   logic [15:0] mem [0:`PM_DEPTH-1];
   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

// ### cst_checker.sv
// assertion checker for the call stack and table read block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module cst_checker (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire pcstk_pkg::core_req_t core_req, // decoder op
   input wire logic core_ready, // op taken
   input wire pcstk_pkg::table_wr_t table_wr, // table low byte write
   input wire logic [11:0] pc, // program counter
   input wire logic int_ack, // interrupt acknowledge
   input wire logic alu_valid, // alu op completes
   input wire logic [7:0] alu_result, // alu result
   input wire logic [7:0] alu_dest, // alu destination
   input wire logic [3:0] alu_flags, // alu flags
   input wire logic alu_wr_valid, // result strobe
   input wire logic [7:0] alu_wr_data, // registered result
   input wire logic [7:0] alu_wr_dest, // registered destination
   input wire logic [3:0] status_flags, // status flags
   input wire logic prog_mode, // programming active
   input wire logic pin_data_oe // data pin enable
);
   // ==========================================================
   // properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire tbl_op = core_ready && core_req.op[2];
   reset_pc_a: assert property ($rose(presetn) |-> pc == 12'h000)
      else $error("pc not at reset vector");
   call_target_a: assert property (
      core_ready && core_req.op == pcstk_pkg::op_call
      |=> pc == $past(core_req.target)) else $error("call target lost");
   table_stall_a: assert property (
      tbl_op |=> !core_ready ##1 core_ready) else $error("table op length");
   table_write_a: assert property (tbl_op |-> ##2 table_wr.valid
      && table_wr.dest == $past(core_req.dest, 2)) else $error("table dest");
   write_cause_a: assert property (
      table_wr.valid |-> $past(tbl_op, 2)) else $error("stray table write");
   alu_write_a: assert property (alu_valid |=> alu_wr_valid
      && alu_wr_data == $past(alu_result) && alu_wr_dest == $past(alu_dest)
      && status_flags == $past(alu_flags)) else $error("alu write wrong");
   prog_pin_a: assert property (prog_mode |-> !pin_data_oe)
      else $error("data pin driven while programming");
   ack_vector_a: assert property (
      int_ack |-> pc == 12'h004 ##1 !int_ack) else $error("ack vector");
endmodule
bind call_stack_and_table_read cst_checker u_chk (.pclk, .presetn,
   .core_req, .core_ready, .table_wr, .pc, .int_ack, .alu_valid,
   .alu_result, .alu_dest, .alu_flags, .alu_wr_valid, .alu_wr_data,
   .alu_wr_dest, .status_flags, .prog_mode, .pin_data_oe);

// ### core_decoder_model.sv
// model of the instruction decoder issuing ops to the block
// assumes ops are taken on an edge where core_ready is high
`timescale 1ns/1ps
module core_decoder_model (
   input wire logic pclk, // clock
   input wire logic core_ready, // op taken
   output pcstk_pkg::core_req_t core_req // op to the block
);
   // ==========================================================
   // op driver
   initial core_req = '0;
   task automatic issue(input pcstk_pkg::op_t o, input logic [11:0] t,
                        input logic [7:0] d, output bit late);
      int n;
      n = 0;
      core_req <= '{o, t, d};
      // held through the table second cycle until taken
      do begin
         @(posedge pclk);
         n++;
      end while (core_ready !== 1'b1 && n < 8);
      late = core_ready !== 1'b1;
   endtask
   // released fields are inverted so stale values cannot pass
   task automatic idle();
      core_req <= '{pcstk_pkg::op_none, ~core_req.target, ~core_req.dest};
   endtask
endmodule

// ### call_stack_and_table_read_tb.sv
// self-checking testbench for the call stack and table read block
// assumes the checker is bound and the decoder model drives core_req
`timescale 1ns/1ps
module call_stack_and_table_read_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr, pc;
   logic [31:0] pwdata, prdata;
   logic core_ready, int_ack, int_request, fetch_valid, alu_valid;
   pcstk_pkg::core_req_t core_req;
   pcstk_pkg::table_wr_t table_wr;
   logic [15:0] fetch_word;
   logic [7:0] alu_result, alu_dest, alu_wr_data, alu_wr_dest;
   logic [3:0] alu_flags, status_flags;
   logic alu_wr_valid, debug_variant, prog_mode, prog_serial_data_pin_in;
   logic debug_serial_data_pin_in, shared_data_out, shared_data_oe;
   logic shared_data_in, pin_data_out, pin_data_oe;
   integer seed = 71;
   int errors = 0;
   int total_checks = 0;
   logic [31:0] exp_rd[$];
   logic [31:0] exp_tw[$];
   logic [15:0] w[3];
   logic [11:0] wa[3] = '{12'h006, 12'hF06, 12'h306};
   int sel[4] = '{0, 1, 2, 1};
   call_stack_and_table_read u_dut (.*);
   core_decoder_model u_core (.pclk, .core_ready, .core_req);
   // ==========================================================
   // clock, random side traffic, result watcher
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) {alu_valid, alu_flags, alu_dest, alu_result,
      prog_serial_data_pin_in, debug_serial_data_pin_in, shared_data_out,
      shared_data_oe} <= 25'($random(seed));
   function automatic logic [31:0] pop(ref logic [31:0] q[$]);
      return q.size() != 0 ? q.pop_front() : 32'hDEADBEEF;
   endfunction
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) check(prdata, pop(exp_rd));
      if (psel && penable && pready) check(pslverr, paddr > 12'h020);
      if (table_wr.valid === 1'b1) begin
         check({16'h0, table_wr.dest, table_wr.data}, pop(exp_tw));
         check(fetch_valid, 1'b0);
      end
   end
   // ==========================================================
   // tasks
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, s, e);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic fail_wait();
      errors++;
      report_and_stop();
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) fail_wait();
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_rd.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic op(input pcstk_pkg::op_t o, input logic [7:0] d);
      bit late;
      u_core.issue(o, 12'($random(seed)), d, late);
      if (late) fail_wait();
   endtask
   task automatic acks(input int n, output logic [31:0] c);
      c = 0;
      repeat (n) begin
         @(posedge pclk);
         c = c + int_ack;
      end
   endtask
   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] c;
      int i;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {int_request, debug_variant, prog_mode} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      {prog_mode, debug_variant} <= 2'b11;
      rd(12'h018, 32'h6);
      check({pin_data_oe, shared_data_in}, 32'h0);
      {prog_mode, debug_variant} <= 2'b00;
      rd(12'h000, 32'h0);
      rd(12'h024, 32'h0);
      int_request <= 1'b1;
      @(posedge pclk);
      int_request <= 1'b0;
      acks(10, c);
      check(c, 32'h1);
      op(pcstk_pkg::op_return_int, 8'h00);
      u_core.idle();
      rd(12'h000, 32'h0);
      for (i = 0; i < 3; i++) begin
         w[i] = 16'($random(seed));
         apb(1'b1, 12'h01C, {20'h0, wa[i]});
         apb(1'b1, 12'h020, {16'h0, w[i]});
      end
      apb(1'b1, 12'h004, 32'h306);
      for (i = 0; i < 4; i++) begin
         exp_tw.push_back({16'h0, 8'(i + 16), w[sel[i]][7:0]});
         op(pcstk_pkg::op_t'(3'(i + 4)), 8'(i + 16));
         u_core.idle();
         // high byte lands on the edge after the take edge
         @(posedge pclk);
         rd(12'h008, {24'h0, w[sel[i]][15:8]});
      end
      apb(1'b1, 12'h008, 32'h5A);
      rd(12'h008, 32'h5A);
      for (i = 1; i <= 6; i++) begin
         op(pcstk_pkg::op_return, 8'h00);
         u_core.idle();
         rd(12'h000, 32'h80 | ((6 - i) % 6));
      end
      apb(1'b1, 12'h000, 32'h0);
      rd(12'h000, 32'h0);
      for (i = 0; i < 6; i++) op(pcstk_pkg::op_call, 8'h00);
      u_core.idle();
      rd(12'h000, 32'h0);
      int_request <= 1'b1;
      acks(5, c);
      int_request <= 1'b0;
      check(c, 32'h0);
      op(pcstk_pkg::op_call, 8'h00);
      u_core.idle();
      rd(12'h000, 32'h81);
      op(pcstk_pkg::op_return, 8'h00);
      u_core.idle();
      rd(12'h000, 32'h80);
      apb(1'b1, 12'h014, 32'h0);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, 12'h014, 32'h3);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, 12'h010, 32'h3);
      check({31'h0, irq}, 32'h0);
      report_and_stop();
   end
endmodule
